// file: design/tncml_esc_detect.sv
`timescale 1ns/1ps
`default_nettype none
module tncml_esc_detect #(
  parameter int SEC_CYCLES = tncml_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  tncml_esc_if.det esc
);
  logic [31:0] subCnt;
  logic [3:0] quietSec;
  tncml_pkg::tncml_esc_e state;
  tncml_pkg::tncml_esc_e next_state;
  wire secWrap = (subCnt == 32'(SEC_CYCLES - 1));
  wire isEsc = esc.charValid && (esc.charByte == esc.modeEntryChar);
  wire quietDone = (quietSec >= esc.escapeGuardTime);
  wire guardOff = (esc.escapeGuardTime == 4'h0);

  // Quiet time restarts on every character, so gaps are measured to the cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subCnt <= 32'h0;
      quietSec <= 4'h0;
    end else if (esc.charValid) begin
      subCnt <= 32'h0;
      quietSec <= 4'h0;
    end else if (secWrap) begin
      subCnt <= 32'h0;
      if (quietSec != 4'hF) quietSec <= quietSec + 4'h1;
    end else begin
      subCnt <= subCnt + 32'h1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      tncml_pkg::ESC_QUIET: if (!esc.charValid && quietDone) next_state = tncml_pkg::ESC_ARMED;
      tncml_pkg::ESC_ARMED: if (esc.charValid) next_state = isEsc ? tncml_pkg::ESC_ONE : tncml_pkg::ESC_QUIET;
      tncml_pkg::ESC_ONE: begin
        if (esc.charValid) next_state = isEsc ? tncml_pkg::ESC_TWO : tncml_pkg::ESC_QUIET;
        else if (quietDone) next_state = tncml_pkg::ESC_ARMED;
      end
      tncml_pkg::ESC_TWO: begin
        if (esc.charValid) next_state = isEsc ? tncml_pkg::ESC_THREE : tncml_pkg::ESC_QUIET;
        else if (quietDone) next_state = tncml_pkg::ESC_ARMED;
      end
      tncml_pkg::ESC_THREE: begin
        if (esc.charValid) next_state = tncml_pkg::ESC_QUIET;
        else if (quietDone) next_state = tncml_pkg::ESC_QUIET;
      end
      default: next_state = tncml_pkg::ESC_QUIET;
    endcase
    if (!esc.inTransparent || guardOff) next_state = tncml_pkg::ESC_QUIET;
  end

  wire fire = esc.inTransparent && !guardOff && (state == tncml_pkg::ESC_THREE)
    && !esc.charValid && quietDone;
  wire partial = (state == tncml_pkg::ESC_ONE) || (state == tncml_pkg::ESC_TWO)
    || (state == tncml_pkg::ESC_THREE);
  wire drop = esc.inTransparent && partial && esc.charValid && (state == tncml_pkg::ESC_THREE
    || !isEsc);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= tncml_pkg::ESC_QUIET;
      esc.escapeDone <= 1'b0;
      esc.escapeDropped <= 1'b0;
    end else begin
      state <= next_state;
      esc.escapeDone <= fire;
      esc.escapeDropped <= drop;
    end
  end

  esc_guard_zero_a: assert property (@(posedge clk) disable iff (rst)
    esc.escapeDone |-> $past(esc.escapeGuardTime) != 4'h0)
    else $error("escape fired with guard time zero");
  esc_needs_three_a: assert property (@(posedge clk) disable iff (rst)
    esc.escapeDone |-> $past(state) == tncml_pkg::ESC_THREE && !$past(esc.charValid))
    else $error("escape fired without three escape chars and quiet");
endmodule : tncml_esc_detect
`default_nettype wire

// file: design/tncml_esc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tncml_esc_if;
  logic charValid;
  logic [7:0] charByte;
  logic [7:0] modeEntryChar;
  logic [3:0] escapeGuardTime;
  logic inTransparent;
  logic escapeDone;
  logic escapeDropped;
  modport ctrl (output charValid, charByte, modeEntryChar, escapeGuardTime, inTransparent,
    input escapeDone, escapeDropped);
  modport det (input charValid, charByte, modeEntryChar, escapeGuardTime, inTransparent,
    output escapeDone, escapeDropped);
endinterface : tncml_esc_if
`default_nettype wire

// file: design/tncml_pkg.sv
// How it works
// - Carrier source: internal, external or firmware
// - External source: busy only from carrier pin
// - External pin always holds off transmitter keying
// - Idle link check every N ten-second units
// - Zero disables; without v2, disconnect not poll
// - Escape guard time 0-15 seconds, default 1
// - Triple escape plus quiet guard gives prompt
// - Guard zero: only break leaves transparent
// - Mode char configurable, default 03, exits converse
// - Four greeting policies on accepted connect
// - Access list filters packets and outgoing connects
// - Single add or remove; full add errors
// - Entry without sub-id matches any sub-id
// - Post-connect mode, deferred by partial line
// - Outgoing connect takes up to 8 relays
// - Timeout or busy reply stays in command
// - Connect from command only; reissue replaces path
// - Acceptance on answers UA, off answers DM
// - Next free stream; excess gets DM and report
// - Permanent link reconnects on restart, flagged
// - Immediate converse keeps existing links
// - Enabled break returns to command mode
package tncml_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_TIME_S;
  localparam logic [3:0] LINK_UNIT_S = 4'hA;
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_SOFTWARE = 2'h2;
  localparam logic [3:0] GUARD_DEFAULT = 4'h1;
  localparam logic [7:0] MODE_CHAR_DEFAULT = 8'h03;
  localparam logic [1:0] GREET_NONE = 2'h0;
  localparam logic [1:0] GREET_SEND = 2'h1;
  localparam logic [1:0] GREET_DISC = 2'h2;
  localparam logic [1:0] GREET_MAILBOX = 2'h3;
  localparam int LIST_DEPTH = 10;
  localparam int CALL_W = 42;
  localparam logic [3:0] MAX_PATH = 4'h8;
  localparam int NSTREAM = 4;
  typedef enum logic [1:0] {MODE_COMMAND, MODE_CONVERSE, MODE_TRANSPARENT} tncml_mode_e;
  typedef enum logic [2:0] {ESC_QUIET, ESC_ARMED, ESC_ONE, ESC_TWO, ESC_THREE} tncml_esc_e;
endpackage : tncml_pkg

// file: design/tncml_top.sv
`timescale 1ns/1ps
`default_nettype none
module tncml_top #(
  parameter int SEC_CYCLES = tncml_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] carrierSourceSelect,
  input wire logic energyDetect,
  input wire logic dataDetect,
  input wire logic extCarrierPin,
  output logic channelBusy,
  output logic txInhibit,
  input wire logic linkConnected,
  input wire logic linkActivity,
  input wire logic [7:0] linkCheckCount,
  input wire logic protocolV2Enable,
  output logic linkPoll,
  output logic linkDisconnect,
  input wire logic termRxValid,
  input wire logic [7:0] termRxByte,
  input wire logic [7:0] modeEntryChar,
  input wire logic [3:0] escapeGuardTime,
  input wire logic serialBreak,
  input wire logic breakEnable,
  input wire logic converseRequest,
  input wire logic lineEmpty,
  input wire logic noModeInhibit,
  input wire logic conModeTransparent,
  output tncml_pkg::tncml_mode_e mode,
  output logic promptSend,
  output logic escapeAsData,
  input wire logic listEnable,
  input wire logic listAdd,
  input wire logic listRemove,
  input wire logic listClear,
  input wire logic [tncml_pkg::CALL_W-1:0] entryCall,
  input wire logic entryHasSubId,
  input wire logic [3:0] entrySubId,
  output logic listError,
  input wire logic packetValid,
  input wire logic [tncml_pkg::CALL_W-1:0] packetCall,
  input wire logic [3:0] packetSubId,
  output logic packetAccept,
  input wire logic incomingConnect,
  input wire logic connectAccept,
  input wire logic [2:0] linkLimit,
  input wire logic [1:0] greetPolicy,
  input wire logic mailboxAvail,
  output logic sendUa,
  output logic sendDm,
  output logic reportConnectReq,
  output logic [1:0] assignedStream,
  output logic sendGreeting,
  output logic greetDisconnect,
  output logic greetMailbox,
  input wire logic streamRelease,
  input wire logic [1:0] releaseStream,
  input wire logic connectRequest,
  input wire logic [1:0] currentStream,
  input wire logic [3:0] pathLength,
  output logic connectStart,
  output logic pathReplace,
  output logic connectRefused,
  input wire logic connectTimeout,
  input wire logic connectBusyReply,
  output logic reportTimeout,
  output logic reportBusy,
  input wire logic outgoingDone,
  input wire logic permanentLink,
  input wire logic restart,
  output logic [tncml_pkg::NSTREAM-1:0] permanentFlags,
  output logic [tncml_pkg::NSTREAM-1:0] reconnectReq
);
  localparam int NS = tncml_pkg::NSTREAM;

  // Carrier source selection
  wire extSel = (carrierSourceSelect == tncml_pkg::SRC_EXTERNAL);
  wire swSel = (carrierSourceSelect == tncml_pkg::SRC_SOFTWARE);
  wire busySel = extSel ? extCarrierPin : (swSel ? dataDetect : energyDetect);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channelBusy <= 1'b0;
      txInhibit <= 1'b0;
    end else begin
      channelBusy <= busySel;
      txInhibit <= busySel | extCarrierPin;
    end
  end

  // Idle link check, counted in ten-second units
  logic [31:0] subCnt;
  logic [3:0] secCnt;
  logic [7:0] idleUnits;
  wire secTick = (subCnt == 32'(SEC_CYCLES - 1));
  wire unitTick = secTick && (secCnt == tncml_pkg::LINK_UNIT_S - 4'h1);
  wire checkOn = linkConnected && (linkCheckCount != 8'h00);
  wire checkDue = checkOn && (idleUnits == linkCheckCount) && !linkActivity;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subCnt <= 32'h0;
      secCnt <= 4'h0;
      idleUnits <= 8'h00;
      linkPoll <= 1'b0;
      linkDisconnect <= 1'b0;
    end else begin
      subCnt <= (secTick || linkActivity || !checkOn) ? 32'h0 : subCnt + 32'h1;
      if (linkActivity || !checkOn || checkDue) begin
        secCnt <= 4'h0;
        idleUnits <= 8'h00;
      end else if (unitTick) begin
        secCnt <= 4'h0;
        idleUnits <= idleUnits + 8'h01;
      end else if (secTick) begin
        secCnt <= secCnt + 4'h1;
      end
      linkPoll <= checkDue && protocolV2Enable;
      linkDisconnect <= checkDue && !protocolV2Enable;
    end
  end

  // Access list, two comparators per entry (packet call and entry call)
  logic [tncml_pkg::CALL_W-1:0] listCall [tncml_pkg::LIST_DEPTH];
  logic [tncml_pkg::LIST_DEPTH-1:0] listUsed;
  logic [tncml_pkg::LIST_DEPTH-1:0] listSubOn;
  logic [3:0] listSub [tncml_pkg::LIST_DEPTH];
  logic [tncml_pkg::LIST_DEPTH-1:0] pktHit;
  logic [tncml_pkg::LIST_DEPTH-1:0] entryHit;
  logic [tncml_pkg::LIST_DEPTH-1:0] freeMask;
  logic [tncml_pkg::LIST_DEPTH-1:0] firstFree;
  genvar gi;
  generate
    for (gi = 0; gi < tncml_pkg::LIST_DEPTH; gi++) begin : gEntry
      assign pktHit[gi] = listUsed[gi] && (listCall[gi] == packetCall)
        && (!listSubOn[gi] || (listSub[gi] == packetSubId));
      assign entryHit[gi] = listUsed[gi] && (listCall[gi] == entryCall)
        && (listSubOn[gi] == entryHasSubId) && (!entryHasSubId || listSub[gi] == entrySubId);
      assign freeMask[gi] = !listUsed[gi];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          listUsed[gi] <= 1'b0;
          listSubOn[gi] <= 1'b0;
          listSub[gi] <= 4'h0;
          listCall[gi] <= '0;
        end else if (listClear || (listRemove && entryHit[gi])) begin
          listUsed[gi] <= 1'b0;
        end else if (listAdd && !(|entryHit) && firstFree[gi]) begin
          listUsed[gi] <= 1'b1;
          listSubOn[gi] <= entryHasSubId;
          listSub[gi] <= entrySubId;
          listCall[gi] <= entryCall;
        end
      end
    end
  endgenerate
  assign firstFree = freeMask & (~freeMask + 10'h001);
  wire listFull = (freeMask == '0);
  wire pktPass = !listEnable || (|pktHit);
  wire destPass = !listEnable || (|pktHit);

  // Stream allocation
  logic [NS-1:0] streamBusy;
  logic [1:0] freeIdx;
  logic freeFound;
  always_comb begin
    freeIdx = 2'h0;
    freeFound = 1'b0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (!streamBusy[i] && (3'(i) < linkLimit)) begin
        freeIdx = 2'(i);
        freeFound = 1'b1;
      end
    end
  end
  wire inTake = incomingConnect && pktPass;
  wire inAccept = inTake && connectAccept && freeFound;
  wire inRefuse = inTake && !inAccept;
  wire inCommand = (mode == tncml_pkg::MODE_COMMAND);
  wire outOk = connectRequest && inCommand && destPass && (pathLength <= tncml_pkg::MAX_PATH);
  wire curBusy = streamBusy[currentStream];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      streamBusy <= '0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (inAccept && freeIdx == 2'(i)) streamBusy[i] <= 1'b1;
        else if (outOk && currentStream == 2'(i)) streamBusy[i] <= 1'b1;
        else if (streamRelease && releaseStream == 2'(i)) streamBusy[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      listError <= 1'b0;
      packetAccept <= 1'b0;
      sendUa <= 1'b0;
      sendDm <= 1'b0;
      reportConnectReq <= 1'b0;
      assignedStream <= 2'h0;
      sendGreeting <= 1'b0;
      greetDisconnect <= 1'b0;
      greetMailbox <= 1'b0;
      connectStart <= 1'b0;
      pathReplace <= 1'b0;
      connectRefused <= 1'b0;
      reportTimeout <= 1'b0;
      reportBusy <= 1'b0;
    end else begin
      listError <= listAdd && !(|entryHit) && listFull;
      packetAccept <= packetValid && pktPass;
      sendUa <= inAccept;
      sendDm <= inRefuse;
      reportConnectReq <= inRefuse;
      if (inAccept) assignedStream <= freeIdx;
      sendGreeting <= inAccept && (greetPolicy != tncml_pkg::GREET_NONE);
      greetDisconnect <= inAccept && ((greetPolicy == tncml_pkg::GREET_DISC)
        || (greetPolicy == tncml_pkg::GREET_MAILBOX && !mailboxAvail));
      greetMailbox <= inAccept && greetPolicy == tncml_pkg::GREET_MAILBOX && mailboxAvail;
      connectStart <= outOk && !curBusy;
      pathReplace <= outOk && curBusy;
      connectRefused <= connectRequest && !outOk;
      reportTimeout <= connectTimeout;
      reportBusy <= connectBusyReply;
    end
  end

  // Permanent links survive a warm restart and are re-requested after it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      permanentFlags <= '0;
      reconnectReq <= '0;
    end else begin
      reconnectReq <= restart ? permanentFlags : '0;
      if (streamRelease && !restart) permanentFlags[releaseStream] <= 1'b0;
      // Later assignment wins, so marking beats a release of the same stream
      if (permanentLink) permanentFlags[currentStream] <= 1'b1;
    end
  end

  // Terminal-side mode control
  tncml_esc_if escBus ();
  assign escBus.charValid = termRxValid;
  assign escBus.charByte = termRxByte;
  assign escBus.modeEntryChar = modeEntryChar;
  assign escBus.escapeGuardTime = escapeGuardTime;
  assign escBus.inTransparent = (mode == tncml_pkg::MODE_TRANSPARENT);
  tncml_esc_detect #(.SEC_CYCLES(SEC_CYCLES)) uEsc (
    .clk(clk),
    .rst(rst),
    .esc(escBus)
  );

  logic modePending;
  tncml_pkg::tncml_mode_e next_mode;
  // A break in command mode also cancels any switch due in the same cycle
  wire breakExit = serialBreak && breakEnable;
  wire convExit = (mode == tncml_pkg::MODE_CONVERSE) && termRxValid
    && (termRxByte == modeEntryChar);
  wire connDone = (inAccept || outgoingDone) && !noModeInhibit;
  wire pendNow = modePending || connDone;
  wire connMode = conModeTransparent;

  always_comb begin
    next_mode = mode;
    if (breakExit || escBus.escapeDone || convExit) next_mode = tncml_pkg::MODE_COMMAND;
    else if (inCommand && converseRequest) next_mode = tncml_pkg::MODE_CONVERSE;
    else if (inCommand && pendNow && lineEmpty)
      next_mode = connMode ? tncml_pkg::MODE_TRANSPARENT : tncml_pkg::MODE_CONVERSE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= tncml_pkg::MODE_COMMAND;
      modePending <= 1'b0;
      promptSend <= 1'b0;
      escapeAsData <= 1'b0;
    end else begin
      mode <= next_mode;
      modePending <= inCommand && pendNow && !lineEmpty && !converseRequest;
      promptSend <= escBus.escapeDone;
      escapeAsData <= escBus.escapeDropped;
    end
  end

  ext_busy_a: assert property (@(posedge clk) disable iff (rst)
    $past(carrierSourceSelect) == tncml_pkg::SRC_EXTERNAL |-> channelBusy == $past(extCarrierPin))
    else $error("external carrier not followed");
  ext_holdoff_a: assert property (@(posedge clk) disable iff (rst)
    $past(extCarrierPin) |-> txInhibit)
    else $error("carrier pin did not hold off keying");
  refuse_dm_a: assert property (@(posedge clk) disable iff (rst)
    incomingConnect && pktPass && !connectAccept |=> sendDm && reportConnectReq && !sendUa)
    else $error("refused connect not answered with DM");
  check_zero_a: assert property (@(posedge clk) disable iff (rst)
    $past(linkCheckCount) == 8'h00 |-> !linkPoll && !linkDisconnect)
    else $error("link check fired while disabled");
  check_kind_a: assert property (@(posedge clk) disable iff (rst)
    linkPoll |-> $past(protocolV2Enable) && !linkDisconnect)
    else $error("poll issued without v2 protocol");
  list_full_a: assert property (@(posedge clk) disable iff (rst)
    listAdd && listFull && !(|entryHit) |=> listError ##1 (!listError || $past(listAdd)))
    else $error("full add did not report one error");
  out_command_a: assert property (@(posedge clk) disable iff (rst)
    (connectStart || pathReplace) |-> $past(mode) == tncml_pkg::MODE_COMMAND)
    else $error("outgoing connect outside command mode");
  break_exit_a: assert property (@(posedge clk) disable iff (rst)
    serialBreak && breakEnable |=> mode == tncml_pkg::MODE_COMMAND)
    else $error("break did not return to command mode");
  prompt_mode_a: assert property (@(posedge clk) disable iff (rst)
    promptSend |-> mode == tncml_pkg::MODE_COMMAND && $past(mode, 2) == tncml_pkg::MODE_TRANSPARENT)
    else $error("prompt without leaving transparent");
endmodule : tncml_top
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int S = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] carrierSourceSelect, greetPolicy, releaseStream, currentStream;
  logic energyDetect, dataDetect, carrierOn, linkConnected, linkActivity, protocolV2Enable;
  logic serialBreak, breakEnable, converseRequest, lineEmpty, noModeInhibit, conModeTransparent;
  logic listEnable, listAdd, listRemove, listClear, entryHasSubId, packetValid, incomingConnect;
  logic connectAccept, mailboxAvail, streamRelease, connectRequest, connectTimeout, restart;
  logic connectBusyReply, outgoingDone, permanentLink;
  logic [7:0] linkCheckCount, modeEntryChar;
  logic [3:0] escapeGuardTime, entrySubId, packetSubId, pathLength;
  logic [2:0] linkLimit;
  logic [41:0] entryCall, packetCall;
  wire extCarrierPin, termRxValid, channelBusy, txInhibit, linkPoll, linkDisconnect, promptSend;
  wire escapeAsData, listError, packetAccept, sendUa, sendDm, reportConnectReq, sendGreeting;
  wire greetDisconnect, greetMailbox, connectStart, pathReplace, connectRefused, reportTimeout;
  wire reportBusy;
  wire [7:0] termRxByte;
  wire [1:0] assignedStream;
  wire [3:0] permanentFlags, reconnectReq;
  tncml_pkg::tncml_mode_e mode;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire [5:0] ev = {packetAccept, listError, escapeAsData, promptSend, linkDisconnect, linkPoll};
  tncml_top #(.SEC_CYCLES(S)) dut (.*);
  tncml_term_model term (.clk(clk), .carrierOn(carrierOn), .extCarrierPin(extCarrierPin),
    .termRxValid(termRxValid), .termRxByte(termRxByte));
  always #50 clk = ~clk;
  function automatic logic busyExp(input logic [1:0] s, input logic [2:0] v);
    return s == 2'h1 ? v[0] : (s == 2'h2 ? v[1] : v[2]);
  endfunction : busyExp
  // Greeting outputs as {mailbox, disconnect, greeting}
  function automatic logic [2:0] greetExp(input logic [1:0] p, input logic m);
    return {p == 2'h3 && m, p == 2'h2 || (p == 2'h3 && !m), p != 2'h0};
  endfunction : greetExp
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic clr();
    {linkActivity, serialBreak, converseRequest, listAdd, listRemove, listClear} = '0;
    {packetValid, incomingConnect, streamRelease, connectRequest, connectTimeout} = '0;
    {connectBusyReply, permanentLink, restart, outgoingDone} = '0;
  endtask : clr
  task automatic nx();
    tick();
    clr();
  endtask : nx
  // Pulse index 0 poll, 1 disconnect, 2 prompt, 3 escape as data, 4 list error, 5 accept
  task automatic evt(input int i, input logic e, input int w);
    logic hit;
    hit = 1'b0;
    repeat (w) begin
      hit |= ev[i] === 1'b1;
      tick();
    end
    chk($sformatf("event %0d", i), e, hit);
  endtask : evt
  task automatic lst(input logic rm, input logic [41:0] c, input logic h, input logic e);
    tick();
    entryCall = c;
    entryHasSubId = h;
    entrySubId = 4'h5;
    listAdd = !rm;
    listRemove = rm;
    nx();
    evt(4, e, 2);
  endtask : lst
  task automatic pkt(input logic [41:0] c, input logic [3:0] s, input logic e);
    tick();
    packetCall = c;
    packetSubId = s;
    packetValid = 1'b1;
    nx();
    evt(5, e, 2);
  endtask : pkt
  task automatic conn(input logic [3:0] n, input logic [2:0] e);
    tick();
    pathLength = n;
    connectRequest = 1'b1;
    nx();
    chk("connect", e, {connectRefused, pathReplace, connectStart});
  endtask : conn
  task automatic inc(input logic a);
    tick();
    connectAccept = a;
    incomingConnect = 1'b1;
    nx();
  endtask : inc
  task automatic brk(input logic en);
    tick();
    breakEnable = en;
    serialBreak = 1'b1;
    nx();
  endtask : brk
  task automatic relAll();
    for (int s = 0; s < 4; s++) begin
      tick();
      releaseStream = 2'(s);
      streamRelease = 1'b1;
      nx();
    end
  endtask : relAll
  initial begin
    logic [41:0] calls [10];
    logic [7:0] ch;
    logic [2:0] b3;
    logic b;
    int k;
    int g;
    void'($urandom(32'hD5D30433));
    {carrierSourceSelect, energyDetect, dataDetect, carrierOn, linkConnected} = '0;
    {protocolV2Enable, breakEnable, lineEmpty, noModeInhibit, conModeTransparent} = '0;
    {listEnable, entryHasSubId, connectAccept, mailboxAvail, greetPolicy, releaseStream} = '0;
    {currentStream, linkCheckCount, modeEntryChar, escapeGuardTime, entrySubId} = '0;
    {packetSubId, pathLength, linkLimit, entryCall, packetCall} = '0;
    clr();
    tick(8);
    rst = 1'b0;
    tick();
    chk("mode", tncml_pkg::MODE_COMMAND, mode);
    chk("flags", 4'h0, permanentFlags);
    for (int i = 0; i < 24; i++) begin
      carrierSourceSelect = 2'($urandom);
      {energyDetect, dataDetect, carrierOn} = 3'($urandom);
      tick();
      b = busyExp(carrierSourceSelect, {energyDetect, dataDetect, carrierOn});
      chk("busy", b, channelBusy);
      chk("inhibit", b | carrierOn, txInhibit);
    end
    linkConnected = 1'b1;
    linkCheckCount = 8'h01;
    protocolV2Enable = 1'b1;
    for (k = 0; k < 130 && ev[0] !== 1'b1; k++) tick();
    chk("poll at", 1'b1, k > 97 && k < 104);
    protocolV2Enable = 1'b0;
    linkActivity = 1'b1;
    nx();
    for (k = 0; k < 130 && ev[1] !== 1'b1; k++) tick();
    chk("disc at", 1'b1, k > 96 && k < 103);
    linkCheckCount = 8'h00;
    protocolV2Enable = 1'b1;
    evt(0, 1'b0, 230);
    linkConnected = 1'b0;
    listEnable = 1'b1;
    listClear = 1'b1;
    nx();
    for (int i = 0; i < 10; i++) begin
      calls[i] = {10'($urandom), $urandom};
      lst(1'b0, calls[i], i == 1, 1'b0);
    end
    lst(1'b0, 42'h3FF_0000_0001, 1'b0, 1'b1);
    pkt(calls[0], 4'($urandom), 1'b1);
    pkt(calls[1], 4'h5, 1'b1);
    pkt(calls[1], 4'h6, 1'b0);
    pkt(42'h3FF_0000_0001, 4'h0, 1'b0);
    lst(1'b1, calls[0], 1'b0, 1'b0);
    pkt(calls[0], 4'h0, 1'b0);
    conn(4'h2, 3'b100);
    listEnable = 1'b0;
    pkt(calls[0], 4'h0, 1'b1);
    linkLimit = 3'h4;
    noModeInhibit = 1'b1;
    for (int i = 0; i < 8; i++) begin
      greetPolicy = 2'(i);
      mailboxAvail = i[2];
      inc(1'b1);
      b3 = greetExp(greetPolicy, mailboxAvail);
      chk("greet", b3, {greetMailbox, greetDisconnect, sendGreeting});
      chk("ua", 2'h2, {sendUa, sendDm});
      chk("stream", 2'h0, assignedStream);
      relAll();
    end
    inc(1'b0);
    chk("dm", 2'h3, {sendDm, reportConnectReq});
    linkLimit = 3'h2;
    for (int i = 0; i < 3; i++) begin
      inc(1'b1);
      chk("limit", {i == 2, i != 2}, {sendDm, sendUa});
      if (i < 2) chk("next", 2'(i), assignedStream);
    end
    relAll();
    noModeInhibit = 1'b0;
    inc(1'b1);
    chk("deferred", tncml_pkg::MODE_COMMAND, mode);
    lineEmpty = 1'b1;
    tick(2);
    chk("conmode", tncml_pkg::MODE_CONVERSE, mode);
    ch = 8'($urandom);
    modeEntryChar = ch;
    term.sendChar(ch);
    chk("entry char", tncml_pkg::MODE_COMMAND, mode);
    converseRequest = 1'b1;
    nx();
    chk("converse", tncml_pkg::MODE_CONVERSE, mode);
    conModeTransparent = 1'b1;
    inc(1'b1);
    chk("no change", tncml_pkg::MODE_CONVERSE, mode);
    brk(1'b0);
    chk("brk off", tncml_pkg::MODE_CONVERSE, mode);
    brk(1'b1);
    chk("brk on", tncml_pkg::MODE_COMMAND, mode);
    relAll();
    inc(1'b1);
    chk("trans", tncml_pkg::MODE_TRANSPARENT, mode);
    g = $urandom_range(15, 1);
    escapeGuardTime = 4'(g);
    tick(g * S + 5);
    term.sendChar(ch);
    term.sendChar(~ch);
    evt(3, 1'b1, 3);
    term.escape(ch, g * S + 5);
    evt(2, 1'b1, g * S + 8);
    chk("escape", tncml_pkg::MODE_COMMAND, mode);
    relAll();
    inc(1'b1);
    escapeGuardTime = 4'h0;
    term.escape(ch, 20);
    evt(2, 1'b0, 30);
    chk("guard 0", tncml_pkg::MODE_TRANSPARENT, mode);
    brk(1'b1);
    chk("brk exit", tncml_pkg::MODE_COMMAND, mode);
    packetCall = 42'h5;
    currentStream = 2'($urandom_range(3, 1));
    conn(4'h8, 3'b001);
    conn(4'h3, 3'b010);
    conn(4'h9, 3'b100);
    connectTimeout = 1'b1;
    nx();
    chk("timeout", 2'h2, {reportTimeout, reportBusy});
    tick();
    connectBusyReply = 1'b1;
    nx();
    chk("busy reply", 2'h1, {reportTimeout, reportBusy});
    chk("stay", tncml_pkg::MODE_COMMAND, mode);
    outgoingDone = 1'b1;
    nx();
    chk("out mode", tncml_pkg::MODE_TRANSPARENT, mode);
    brk(1'b1);
    tick();
    converseRequest = 1'b1;
    nx();
    conn(4'h2, 3'b100);
    currentStream = 2'h2;
    permanentLink = 1'b1;
    nx();
    chk("perm", 4'h4, permanentFlags);
    tick();
    restart = 1'b1;
    nx();
    chk("reconnect", 4'h4, reconnectReq);
    tick();
    chk("perm kept", 4'h4, permanentFlags);
    stop_test();
  end
  // Tests need about 1250 cycles; the 30000-cycle limit, over twenty times that, means a hang
  initial begin
    #3_000_000;
    n_mismatch++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// file: verification/tncml_term_model.sv
`timescale 1ns/1ps
`default_nettype none
module tncml_term_model (
  input wire logic clk,
  input wire logic carrierOn,
  output logic extCarrierPin,
  output logic termRxValid,
  output logic [7:0] termRxByte
);
  assign extCarrierPin = carrierOn;
  initial begin
    termRxValid = 1'b0;
    termRxByte = 8'h00;
  end
  // Idle data shows the inverse of the last byte so a stale byte never looks new
  task automatic sendChar(input logic [7:0] b);
    @(negedge clk);
    termRxValid = 1'b1;
    termRxByte = b;
    @(negedge clk);
    termRxValid = 1'b0;
    termRxByte = ~b;
  endtask : sendChar
  // Gaps of four cycles stay below any guard of one second or more
  task automatic escape(input logic [7:0] c, input int quiet);
    repeat (quiet) @(negedge clk);
    repeat (3) begin
      sendChar(c);
      repeat (3) @(negedge clk);
    end
  endtask : escape
endmodule : tncml_term_model
`default_nettype wire
